// ---- logic/fcs_defs.vh ----
// constants of the converter fault supervisor
//
// Behaviour
// - With decoding off, each of the four optical gating inputs drives its own switch gate output.
// - The gate outputs come from the optical inputs, either directly or through a table of switching states.
// - Any present fault overrides the inputs with all switches off or the one shared short state, the choice made per cause.
// - Each fault cause has its own latched fault flag output.
// - The fast monitor checks bus voltage and output current at about 150 ksps against their limits.
// - The slow monitor checks heatsink temperature and the 5 V supply against their limits.
// - Default limits are 30 A current, 450 V per half bus, 90 degC and a 4.5 V to 5.5 V supply.
// - The global fault output is active low: high in normal operation and low once a fault is seen.
// - A tripped fault stays until the clear button input, or a software clear, releases it.
// - The global fault output is the level that is forwarded to the master controller.
`ifndef FCS_DEFS_VH
`define FCS_DEFS_VH

// ============================================================
// timing
`define FCS_CLK_PERIOD_NS       10
`define FCS_FAST_SAMPLE_NS      6667
`define FCS_FAST_SAMPLE_CYCLES  (`FCS_FAST_SAMPLE_NS / `FCS_CLK_PERIOD_NS)
`define FCS_SLOW_SAMPLE_US      1000
`define FCS_SLOW_SAMPLE_CYCLES  (`FCS_SLOW_SAMPLE_US * 1000 / `FCS_CLK_PERIOD_NS)

// ============================================================
// register byte offsets
`define FCS_OFS_CTRL            8'h00
`define FCS_OFS_FAULT_MODE      8'h04
`define FCS_OFS_SHORT_PATTERN   8'h08
`define FCS_OFS_DECODE_TABLE    8'h0C
`define FCS_OFS_CURRENT_LIMIT   8'h10
`define FCS_OFS_VOLTAGE_LIMIT   8'h14
`define FCS_OFS_TEMP_LIMIT      8'h18
`define FCS_OFS_SUPPLY_MIN      8'h1C
`define FCS_OFS_SUPPLY_MAX      8'h20
`define FCS_OFS_FAULT_STATE     8'h24
`define FCS_OFS_IRQ_STATUS      8'h28
`define FCS_OFS_IRQ_MASK        8'h2C
`define FCS_OFS_GATE_STATE      8'h30
`define FCS_OFS_FIRST_FAULT     8'h34
`define FCS_OFS_TRIP_COUNT      8'h38

// ============================================================
// fields
`define FCS_CTRL_DECODE_BIT     0
`define FCS_CTRL_ACK_BIT        1
`define FCS_CTRL_ENABLE_BIT     2
`define FCS_NUM_FAULTS          5
`define FCS_FLT_OC              0
`define FCS_FLT_OV              1
`define FCS_FLT_TEMP            2
`define FCS_FLT_PSU             3
`define FCS_FLT_DSAT            4
`define FCS_GLOBAL_BIT          8

// ============================================================
// reset values; current 0.1 A, voltage 0.1 V, temperature 0.1 degC, supply mV
`define FCS_RST_CTRL            3'h4
`define FCS_RST_FAULT_MODE      5'h00
`define FCS_RST_SHORT_PATTERN   4'h6
`define FCS_RST_DECODE_TABLE    16'h3C60
`define FCS_RST_CURRENT_LIMIT   16'h012C
`define FCS_RST_VOLTAGE_LIMIT   16'h1194
`define FCS_RST_TEMP_LIMIT      16'h0384
`define FCS_RST_SUPPLY_MIN      16'h1194
`define FCS_RST_SUPPLY_MAX      16'h157C
`define FCS_RST_IRQ_MASK        5'h1F

`endif

// ---- logic/fcs_sync.v ----
// two-stage synchroniser for asynchronous pins
`timescale 1ns/10ps
module fcs_sync
#(
  parameter WIDTH    = 1,
  parameter RESET_LO = 0
)
(
  input  wire             clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_reg;

  // ============================================================
  // stage one is read by stage two only
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1_reg <= {WIDTH{RESET_LO == 0}};
      syncOut    <= {WIDTH{RESET_LO == 0}};
    end
    else
    begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end

endmodule // fcs_sync

// ---- logic/fcs_fault_latch.v ----
// one latched fault cause with its active-low flag
`timescale 1ns/10ps
module fcs_fault_latch
(
  input  wire clk,
  input  wire resetn,
  input  wire setIn,
  input  wire clearIn,
  output reg  latched,
  output reg  flagN
);

  wire latched_next;

  // ============================================================
  // trip holds until cleared; a trip in the clear cycle wins
  assign latched_next = setIn | (latched & ~clearIn);

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      latched <= 1'b0;
      flagN   <= 1'b1;
    end
    else
    begin
      latched <= latched_next;
      flagN   <= ~latched_next;
    end
  end

endmodule // fcs_fault_latch

// ---- logic/fcs_supervisor.v ----
// converter fault supervisor: gate mapping, limit monitors, fault latching, apb registers
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "fcs_defs.vh"
module fcs_supervisor
#(
  parameter FAST_CYCLES = `FCS_FAST_SAMPLE_CYCLES,
  parameter SLOW_CYCLES = `FCS_SLOW_SAMPLE_CYCLES
)
(
  input  wire        clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        opticalGateA,
  input  wire        opticalGateB,
  input  wire        opticalGateC,
  input  wire        opticalGateD,
  input  wire        faultAck,
  input  wire        driverDesatN,
  input  wire [15:0] currentSample,
  input  wire [15:0] busVoltUpper,
  input  wire [15:0] busVoltLower,
  input  wire [15:0] heatsinkTemp,
  input  wire [15:0] supplyMilliVolt,
  output reg         switchDriveA,
  output reg         switchDriveB,
  output reg         switchDriveC,
  output reg         switchDriveD,
  output wire        overcurrentFlagN,
  output wire        overvoltageFlagN,
  output wire        temperatureFlagN,
  output wire        supplyFlagN,
  output wire        desaturationFlagN,
  output reg         globalFaultN,
  output reg         irq
);

  localparam NF = `FCS_NUM_FAULTS;
  localparam [31:0] FAST_LAST = FAST_CYCLES - 1;
  localparam [31:0] SLOW_LAST = SLOW_CYCLES - 1;

  // ============================================================
  // registers
  reg  [2:0]    ctrl_reg;
  reg  [NF-1:0] faultMode_reg;
  reg  [3:0]    shortPattern_reg;
  reg  [15:0]   decodeTable_reg;
  reg  [15:0]   currentLimit_reg;
  reg  [15:0]   voltageLimit_reg;
  reg  [15:0]   tempLimit_reg;
  reg  [15:0]   supplyMin_reg;
  reg  [15:0]   supplyMax_reg;
  reg  [NF-1:0] irqStatus_reg;
  reg  [NF-1:0] irqStatus_next;
  reg  [NF-1:0] irqMask_reg;
  reg  [NF-1:0] firstFault_reg;
  reg  [15:0]   tripCount_reg;
  reg  [16:0]   fastCnt_reg;
  reg  [16:0]   slowCnt_reg;
  reg           fastTick_reg;
  reg           slowTick_reg;
  reg           ackPrev_reg;
  reg  [31:0]   readMux;
  reg           readErr;
  reg  [3:0]    decoded;
  reg  [3:0]    drive_next;

  wire [3:0]    gateSync;
  wire          ackSync;
  wire          desatSyncN;
  wire          ackPulse;
  wire          swAck;
  wire          apbWrite;
  wire          apbRead;
  wire [15:0]   absCurrent;
  wire [NF-1:0] fltSet;
  wire [NF-1:0] latched;
  wire [NF-1:0] flagsN;
  wire [NF-1:0] faultNow;
  wire [NF-1:0] newTrip;
  wire [3:0]    normalGate;
  wire          blockFault;
  wire          shortFault;

  // ============================================================
  // pin synchronisers
  fcs_sync #(.WIDTH(4), .RESET_LO(1)) gateSyncInst
  (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn ({opticalGateD, opticalGateC, opticalGateB, opticalGateA}),
    .syncOut (gateSync)
  );

  fcs_sync #(.WIDTH(1), .RESET_LO(1)) ackSyncInst
  (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (faultAck),
    .syncOut (ackSync)
  );

  fcs_sync #(.WIDTH(1), .RESET_LO(0)) desatSyncInst
  (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (driverDesatN),
    .syncOut (desatSyncN)
  );

  // ============================================================
  // apb access
  assign apbWrite = psel & penable & pready & pwrite;
  assign apbRead  = psel & penable & pready & ~pwrite;
  assign swAck    = apbWrite & (paddr == `FCS_OFS_CTRL) & pwdata[`FCS_CTRL_ACK_BIT];

  always @*
  begin
    readMux = 32'h00000000;
    readErr = 1'b0;
    case (paddr)
      `FCS_OFS_CTRL:          readMux[2:0]  = ctrl_reg & 3'h5;
      `FCS_OFS_FAULT_MODE:    readMux[4:0]  = faultMode_reg;
      `FCS_OFS_SHORT_PATTERN: readMux[3:0]  = shortPattern_reg;
      `FCS_OFS_DECODE_TABLE:  readMux[15:0] = decodeTable_reg;
      `FCS_OFS_CURRENT_LIMIT: readMux[15:0] = currentLimit_reg;
      `FCS_OFS_VOLTAGE_LIMIT: readMux[15:0] = voltageLimit_reg;
      `FCS_OFS_TEMP_LIMIT:    readMux[15:0] = tempLimit_reg;
      `FCS_OFS_SUPPLY_MIN:    readMux[15:0] = supplyMin_reg;
      `FCS_OFS_SUPPLY_MAX:    readMux[15:0] = supplyMax_reg;
      `FCS_OFS_FAULT_STATE:
      begin
        readMux[4:0]              = latched;
        readMux[`FCS_GLOBAL_BIT]  = ~globalFaultN;
      end
      `FCS_OFS_IRQ_STATUS:    readMux[4:0]  = irqStatus_reg;
      `FCS_OFS_IRQ_MASK:      readMux[4:0]  = irqMask_reg;
      `FCS_OFS_GATE_STATE:
      begin
        readMux[3:0] = gateSync;
        readMux[7:4] = {switchDriveD, switchDriveC, switchDriveB, switchDriveA};
      end
      `FCS_OFS_FIRST_FAULT:   readMux[4:0]  = firstFault_reg;
      `FCS_OFS_TRIP_COUNT:    readMux[15:0] = tripCount_reg;
      default:                readErr       = 1'b1;
    endcase
  end

  // read data and answer are taken in the setup cycle: one access cycle, no waits
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      if (psel & ~penable)
      begin
        prdata  <= pwrite ? 32'h00000000 : readMux;
        pslverr <= readErr;
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg         <= `FCS_RST_CTRL;
      faultMode_reg    <= `FCS_RST_FAULT_MODE;
      shortPattern_reg <= `FCS_RST_SHORT_PATTERN;
      decodeTable_reg  <= `FCS_RST_DECODE_TABLE;
      currentLimit_reg <= `FCS_RST_CURRENT_LIMIT;
      voltageLimit_reg <= `FCS_RST_VOLTAGE_LIMIT;
      tempLimit_reg    <= `FCS_RST_TEMP_LIMIT;
      supplyMin_reg    <= `FCS_RST_SUPPLY_MIN;
      supplyMax_reg    <= `FCS_RST_SUPPLY_MAX;
      irqMask_reg      <= `FCS_RST_IRQ_MASK;
    end
    else if (apbWrite)
    begin
      case (paddr)
        `FCS_OFS_CTRL:          ctrl_reg         <= pwdata[2:0] & 3'h5;
        `FCS_OFS_FAULT_MODE:    faultMode_reg    <= pwdata[4:0];
        `FCS_OFS_SHORT_PATTERN: shortPattern_reg <= pwdata[3:0];
        `FCS_OFS_DECODE_TABLE:  decodeTable_reg  <= pwdata[15:0];
        `FCS_OFS_CURRENT_LIMIT: currentLimit_reg <= pwdata[15:0];
        `FCS_OFS_VOLTAGE_LIMIT: voltageLimit_reg <= pwdata[15:0];
        `FCS_OFS_TEMP_LIMIT:    tempLimit_reg    <= pwdata[15:0];
        `FCS_OFS_SUPPLY_MIN:    supplyMin_reg    <= pwdata[15:0];
        `FCS_OFS_SUPPLY_MAX:    supplyMax_reg    <= pwdata[15:0];
        `FCS_OFS_IRQ_MASK:      irqMask_reg      <= pwdata[4:0];
        default:                ctrl_reg         <= ctrl_reg;
      endcase
    end
  end

  // ============================================================
  // sample rate dividers
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fastCnt_reg  <= 17'h00000;
      slowCnt_reg  <= 17'h00000;
      fastTick_reg <= 1'b0;
      slowTick_reg <= 1'b0;
    end
    else
    begin
      fastTick_reg <= (fastCnt_reg == FAST_LAST[16:0]);
      slowTick_reg <= (slowCnt_reg == SLOW_LAST[16:0]);
      fastCnt_reg  <= (fastCnt_reg == FAST_LAST[16:0]) ? 17'h00000 : fastCnt_reg + 17'h00001;
      slowCnt_reg  <= (slowCnt_reg == SLOW_LAST[16:0]) ? 17'h00000 : slowCnt_reg + 17'h00001;
    end
  end

  // ============================================================
  // limit checks
  assign absCurrent = currentSample[15] ? (~currentSample + 16'h0001) : currentSample;

  assign fltSet[`FCS_FLT_OC]   = fastTick_reg & (absCurrent > currentLimit_reg);
  assign fltSet[`FCS_FLT_OV]   = fastTick_reg & ((busVoltUpper > voltageLimit_reg) |
                                                 (busVoltLower > voltageLimit_reg));
  assign fltSet[`FCS_FLT_TEMP] = slowTick_reg & ($signed(heatsinkTemp) > $signed(tempLimit_reg));
  assign fltSet[`FCS_FLT_PSU]  = slowTick_reg & ((supplyMilliVolt < supplyMin_reg) |
                                                 (supplyMilliVolt > supplyMax_reg));
  assign fltSet[`FCS_FLT_DSAT] = ~desatSyncN;

  // ============================================================
  // fault latches, one per cause
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ackPrev_reg <= 1'b0;
    end
    else
    begin
      ackPrev_reg <= ackSync;
    end
  end

  assign ackPulse = (ackSync & ~ackPrev_reg) | swAck;

  genvar gi;
  generate
    for (gi = 0; gi < NF; gi = gi + 1)
    begin : faultGen
      fcs_fault_latch faultInst
      (
        .clk     (clk),
        .resetn  (resetn),
        .setIn   (fltSet[gi]),
        .clearIn (ackPulse),
        .latched (latched[gi]),
        .flagN   (flagsN[gi])
      );
    end
  endgenerate

  assign overcurrentFlagN  = flagsN[`FCS_FLT_OC];
  assign overvoltageFlagN  = flagsN[`FCS_FLT_OV];
  assign temperatureFlagN  = flagsN[`FCS_FLT_TEMP];
  assign supplyFlagN       = flagsN[`FCS_FLT_PSU];
  assign desaturationFlagN = flagsN[`FCS_FLT_DSAT];

  assign faultNow = fltSet | (latched & ~{NF{ackPulse}});
  assign newTrip  = fltSet & ~latched;

  // ============================================================
  // gate generation
  assign normalGate = gateSync;

  always @*
  begin
    decoded = 4'h0;
    case (gateSync[1:0])
      2'h0:    decoded = decodeTable_reg[3:0];
      2'h1:    decoded = decodeTable_reg[7:4];
      2'h2:    decoded = decodeTable_reg[11:8];
      2'h3:    decoded = decodeTable_reg[15:12];
      default: decoded = 4'h0;
    endcase
  end

  // blocking wins over the short state when both kinds of cause are present
  assign blockFault = |(faultNow & ~faultMode_reg);
  assign shortFault = |(faultNow & faultMode_reg);

  always @*
  begin
    drive_next = ctrl_reg[`FCS_CTRL_DECODE_BIT] ? decoded : normalGate;
    if (!ctrl_reg[`FCS_CTRL_ENABLE_BIT])
    begin
      drive_next = 4'h0;
    end
    if (blockFault)
    begin
      drive_next = 4'h0;
    end
    else if (shortFault)
    begin
      drive_next = shortPattern_reg;
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      switchDriveA <= 1'b0;
      switchDriveB <= 1'b0;
      switchDriveC <= 1'b0;
      switchDriveD <= 1'b0;
      globalFaultN <= 1'b1;
    end
    else
    begin
      switchDriveA <= drive_next[0];
      switchDriveB <= drive_next[1];
      switchDriveC <= drive_next[2];
      switchDriveD <= drive_next[3];
      globalFaultN <= ~(|faultNow);
    end
  end

  // ============================================================
  // interrupt status, first cause and trip count
  always @*
  begin
    irqStatus_next = irqStatus_reg;
    if (apbRead && (paddr == `FCS_OFS_IRQ_STATUS))
    begin
      irqStatus_next = irqStatus_reg & ~prdata[4:0];
    end
    irqStatus_next = irqStatus_next | newTrip;
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irqStatus_reg  <= 5'h00;
      irq            <= 1'b0;
      firstFault_reg <= 5'h00;
      tripCount_reg  <= 16'h0000;
    end
    else
    begin
      irqStatus_reg <= irqStatus_next;
      irq           <= |(irqStatus_next & irqMask_reg);
      if (~(|latched) & (|newTrip))
      begin
        firstFault_reg <= newTrip;
      end
      if ((|newTrip) & ~(|latched) & (tripCount_reg != 16'hFFFF))
      begin
        tripCount_reg <= tripCount_reg + 16'h0001;
      end
    end
  end

endmodule // fcs_supervisor

// ---- testbench/fcs_supervisor_checker.sv ----
// port assertions for the converter fault supervisor
`timescale 1ns/10ps
module fcs_supervisor_checker
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic faultAck,
  input wire logic opticalGateA,
  input wire logic opticalGateB,
  input wire logic opticalGateC,
  input wire logic opticalGateD,
  input wire logic switchDriveA,
  input wire logic switchDriveB,
  input wire logic switchDriveC,
  input wire logic switchDriveD,
  input wire logic overcurrentFlagN,
  input wire logic overvoltageFlagN,
  input wire logic temperatureFlagN,
  input wire logic supplyFlagN,
  input wire logic desaturationFlagN,
  input wire logic globalFaultN
);
  wire [3:0] gates  = {opticalGateD, opticalGateC, opticalGateB, opticalGateA};
  wire [3:0] drives = {switchDriveD, switchDriveC, switchDriveB, switchDriveA};
  wire [4:0] flags  = {desaturationFlagN, supplyFlagN, temperatureFlagN, overvoltageFlagN, overcurrentFlagN};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ============================================================
  // properties
  property p_stableDrives; (!psel && $stable(gates) && globalFaultN) [*4] |-> $stable(drives); endproperty
  a_stableDrives: assert property (p_stableDrives) else $error("drives moved without cause");
  property p_flagGlobal; !(&flags) |-> !globalFaultN; endproperty
  a_flagGlobal: assert property (p_flagGlobal) else $error("flag low with global high");
  property p_forcedHold; !globalFaultN && !$past(globalFaultN) |-> $stable(drives); endproperty
  a_forcedHold: assert property (p_forcedHold) else $error("drives follow inputs in fault");
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_readyOnce; pready |=> !pready; endproperty
  a_readyOnce: assert property (p_readyOnce) else $error("ready held too long");
  property p_errReady; pslverr |-> pready; endproperty
  a_errReady: assert property (p_errReady) else $error("error without ready");
  property p_latched; (!globalFaultN && !faultAck && !psel) [*6] |=> !globalFaultN; endproperty
  a_latched: assert property (p_latched) else $error("fault released without clear");
  property p_releaseFlags; $rose(globalFaultN) |-> &flags; endproperty
  a_releaseFlags: assert property (p_releaseFlags) else $error("flag low after release");
  c_trip: cover property ($fell(globalFaultN));
  c_clear: cover property ($rose(globalFaultN));
  c_err: cover property (pslverr);
endmodule // fcs_supervisor_checker
bind fcs_supervisor fcs_supervisor_checker i_chk (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .faultAck(faultAck), .opticalGateA(opticalGateA),
  .opticalGateB(opticalGateB), .opticalGateC(opticalGateC), .opticalGateD(opticalGateD),
  .switchDriveA(switchDriveA), .switchDriveB(switchDriveB), .switchDriveC(switchDriveC),
  .switchDriveD(switchDriveD), .overcurrentFlagN(overcurrentFlagN), .overvoltageFlagN(overvoltageFlagN),
  .temperatureFlagN(temperatureFlagN), .supplyFlagN(supplyFlagN), .desaturationFlagN(desaturationFlagN),
  .globalFaultN(globalFaultN));

// ---- testbench/fcs_master_model.sv ----
// master controller model driving the optical gating links
`timescale 1ns/10ps
module fcs_master_model
(
  input  wire logic clk,
  input  wire logic globalFaultN,
  output wire logic opticalGateA,
  output wire logic opticalGateB,
  output wire logic opticalGateC,
  output wire logic opticalGateD
);
  logic   [3:0] pattern    = 4'h0;
  integer       faultsSeen = 0;
  assign {opticalGateD, opticalGateC, opticalGateB, opticalGateA} = pattern;
  task setGates(input [3:0] v);
    @(posedge clk);
    pattern <= v;
  endtask
  // counts trips reported back over the error link
  always @(negedge globalFaultN) faultsSeen++;
endmodule // fcs_master_model

// ---- testbench/fcs_supervisor_tb.sv ----
// self-checking bench for the converter fault supervisor
`timescale 1ns/10ps
`include "fcs_defs.vh"
module fcs_supervisor_tb;
  localparam FAST = 8;
  localparam SLOW = 16;
  logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, faultAck = 0, driverDesatN = 1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, r;
  logic        e;
  logic [15:0] currentSample = 16'h0000, busVoltUpper = 16'h0000, busVoltLower = 16'h0000;
  logic [15:0] heatsinkTemp = 16'h00FA, supplyMilliVolt = 16'h1388;
  wire  [31:0] prdata;
  wire         pready, pslverr, gA, gB, gC, gD, dA, dB, dC, dD, irq, globalFaultN;
  wire         ocN, ovN, tmN, psN, dsN;
  wire  [3:0]  drives = {dD, dC, dB, dA};
  integer      failures = 0, comparisons = 0, cycles = 0, k;
  fcs_supervisor #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) i_dut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .opticalGateA(gA), .opticalGateB(gB), .opticalGateC(gC), .opticalGateD(gD),
    .faultAck(faultAck), .driverDesatN(driverDesatN), .currentSample(currentSample),
    .busVoltUpper(busVoltUpper), .busVoltLower(busVoltLower), .heatsinkTemp(heatsinkTemp),
    .supplyMilliVolt(supplyMilliVolt), .switchDriveA(dA), .switchDriveB(dB), .switchDriveC(dC),
    .switchDriveD(dD), .overcurrentFlagN(ocN), .overvoltageFlagN(ovN), .temperatureFlagN(tmN),
    .supplyFlagN(psN), .desaturationFlagN(dsN), .globalFaultN(globalFaultN), .irq(irq));
  fcs_master_model i_ctl (.clk(clk), .globalFaultN(globalFaultN), .opticalGateA(gA), .opticalGateB(gB),
    .opticalGateC(gC), .opticalGateD(gD));
  initial forever #5 clk = ~clk;
  // ============================================================
  // shared tasks
  task give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      give_verdict;
    end
  end
  task check(input [31:0] got, input [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input [7:0] a, input w, input [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1 && cycles < 20000);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(r, exp);
  endtask
  task waitTrip;
    for (k = 0; k < 100 && globalFaultN !== 1'b0; k++) @(posedge clk);
  endtask
  task settle;
    repeat (8) @(posedge clk);
  endtask
  task ack;
    @(posedge clk) faultAck <= 1;
    repeat (3) @(posedge clk);
    faultAck <= 0;
    settle;
  endtask
  // ============================================================
  // scenarios
  task t_regs;
    rd(`FCS_OFS_CTRL, `FCS_RST_CTRL);
    rd(`FCS_OFS_IRQ_MASK, `FCS_RST_IRQ_MASK);
    rd(`FCS_OFS_DECODE_TABLE, `FCS_RST_DECODE_TABLE);
    apb(8'h3C, 1'b0, 32'h0);
    check(r, 32'h0);
    check(e, 1);
    $display("registers done");
  endtask
  task t_gates;
    for (int p = 0; p < 16; p += 5)
    begin
      i_ctl.setGates(p);
      settle;
      check(drives, p);
    end
    wr(`FCS_OFS_CTRL, 32'h5);
    for (int c = 0; c < 4; c++)
    begin
      i_ctl.setGates(c);
      settle;
      check(drives, (`FCS_RST_DECODE_TABLE >> (c * 4)) & 16'hF);
    end
    wr(`FCS_OFS_CTRL, 32'h0);
    settle;
    check(drives, 0);
    wr(`FCS_OFS_CTRL, 32'h4);
    rd(`FCS_OFS_GATE_STATE, 32'h33);
    $display("gating done");
  endtask
  task t_current;
    i_ctl.setGates(4'hF);
    @(posedge clk) currentSample <= 16'h012C;
    repeat (3 * FAST) @(posedge clk);
    check(globalFaultN, 1);
    @(posedge clk) currentSample <= 16'hFED3;
    waitTrip;
    currentSample <= 16'h0000;
    check({ocN, globalFaultN, drives}, 6'h0);
    @(posedge clk);
    check(irq, 1);
    rd(`FCS_OFS_FAULT_STATE, 32'h101);
    rd(`FCS_OFS_FIRST_FAULT, 32'h1);
    rd(`FCS_OFS_TRIP_COUNT, 32'h1);
    rd(`FCS_OFS_IRQ_STATUS, 32'h1);
    @(posedge clk);
    check(irq, 0);
    repeat (3 * FAST) @(posedge clk);
    check(globalFaultN, 0);
    ack;
    check({ocN, globalFaultN, drives}, 6'h3F);
    check(i_ctl.faultsSeen, 1);
    $display("current done");
  endtask
  task t_voltage;
    wr(`FCS_OFS_IRQ_MASK, 32'h0);
    @(posedge clk) busVoltLower <= 16'h1195;
    waitTrip;
    busVoltLower <= 16'h1194;
    check({ovN, globalFaultN, irq}, 3'h0);
    rd(`FCS_OFS_IRQ_STATUS, 32'h2);
    wr(`FCS_OFS_IRQ_MASK, 32'h1F);
    wr(`FCS_OFS_CTRL, 32'h6);
    settle;
    check(globalFaultN, 1);
    $display("voltage done");
  endtask
  task t_slow;
    @(posedge clk);
    heatsinkTemp <= 16'h0385;
    supplyMilliVolt <= 16'h1193;
    waitTrip;
    repeat (2) @(posedge clk);
    check({tmN, psN, ocN}, 3'h1);
    rd(`FCS_OFS_FIRST_FAULT, 32'hC);
    rd(`FCS_OFS_TRIP_COUNT, 32'h3);
    heatsinkTemp <= 16'h0384;
    supplyMilliVolt <= 16'h157C;
    ack;
    repeat (3 * SLOW) @(posedge clk);
    check(globalFaultN, 1);
    $display("slow monitor done");
  endtask
  task t_desat;
    wr(`FCS_OFS_FAULT_MODE, 32'h10);
    @(posedge clk) driverDesatN <= 0;
    waitTrip;
    check({dsN, drives}, `FCS_RST_SHORT_PATTERN);
    @(posedge clk) driverDesatN <= 1;
    ack;
    check({globalFaultN, drives}, 5'h1F);
    check(i_ctl.faultsSeen, 4);
    $display("desaturation done");
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1;
    t_regs;
    t_gates;
    t_current;
    t_voltage;
    t_slow;
    t_desat;
    give_verdict;
  end
endmodule // fcs_supervisor_tb
